// [logic/occ_channel.sv]
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - The channel compares its selected timer with one or two compare values and moves the pin on equality.
// - The time base select bit picks the third timer when set and the second timer when clear.
// - Mode 000 disables the channel, raises no interrupt, and the pin follows the port logic.
// - Mode 001 starts the pin low, drives it high on a match and interrupts on that rise.
// - Mode 010 starts the pin high, drives it low on a match and interrupts on that fall.
// - Mode 011 keeps the pin level at entry, inverts it on every match and interrupts on each edge.
// - Mode 100 starts low and makes one pulse from primary to secondary match, interrupting on the fall.
// - Mode 101 starts low and repeats such pulses, interrupting on every fall.
// - Mode 110 is PWM without fault input or interrupt, starting low if the primary value is zero else high.
// - Mode 111 is PWM with the same start level and a fault input whose falling edge interrupts.
// - A read-only fault status bit is set by a PWM fault, cleared by hardware only, and used only in mode 111.
// - With the idle halt bit set the channel freezes while the processor idles, otherwise it keeps running.
// - Control bits 15 to 14 and 12 to 5 ignore writes and read as zero.
module occ_channel
    import occ_pkg::*;
#(
    parameter int CNT_W  = 16,
    parameter int ADDR_W = 8
) (
    input  wire logic              core_clk,           // 100 MHz core clock
    input  wire logic              rst_n,              // Async reset, active low
    input  wire logic              psel,               // APB select
    input  wire logic              penable,            // APB access phase
    input  wire logic              pwrite,             // APB write
    input  wire logic [ADDR_W-1:0] paddr,              // APB byte address
    input  wire logic [31:0]       pwdata,             // APB write data
    output logic      [31:0]       prdata,             // APB read data
    output logic                   pready,             // APB ready
    output logic                   pslverr,            // APB error on unmapped address
    input  wire logic [CNT_W-1:0]  second_timer_count, // Second general timer count
    input  wire logic [CNT_W-1:0]  third_timer_count,  // Third general timer count
    input  wire logic              second_period_hit,  // Second timer period pulse
    input  wire logic              third_period_hit,   // Third timer period pulse
    input  wire logic              cpu_idle,           // Processor is in Idle
    input  wire logic              fault_input_pin,    // Fault input, active low
    input  wire logic              port_level,         // Port logic level for the pin
    output logic                   compare_output_pin, // Compare output
    output logic                   irq                 // Level interrupt
);

    occ_ctrl_t        ctrl;
    logic             pwm_fault_status;
    logic [CNT_W-1:0] primary_compare_value;
    logic [CNT_W-1:0] secondary_compare_value;
    logic [CNT_W-1:0] duty;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic [EVT_W-1:0] evt_set;
    logic             mode_load;
    logic             run;
    logic             cmp_evt;
    logic             flt_evt;
    logic             fault_fall;
    logic             is_pwm;
    logic             acc;
    logic             wr;
    logic             mapped;
    logic [2:0]       mode;
    occ_match_t       match;
    occ_state_t       state;

    assign mode   = ctrl.compare_mode_field;
    assign is_pwm = (mode == MODE_PWM) || (mode == MODE_PWM_FLT);

    // Zero wait states keeps the master's wait trivial
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_PRIMARY) || (paddr == OFS_SECOND)
                   || (paddr == OFS_STATUS) || (paddr == OFS_MASK);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // Control register; bits outside the fields are never stored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl.idle_halt_select   <= pwdata[BIT_IDLE_HALT];
            ctrl.time_base_select   <= pwdata[BIT_TSEL];
            ctrl.compare_mode_field <= pwdata[MODE_MSB:0];
        end
    end

    // Mode entry happens one cycle after the control write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_load <= 1'b0;
        end else begin
            mode_load <= wr && (paddr == OFS_CTRL);
        end
    end

    // Compare value registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_compare_value   <= COMPARE_RST;
            secondary_compare_value <= COMPARE_RST;
        end else if (wr) begin
            if (paddr == OFS_PRIMARY) begin
                primary_compare_value <= pwdata[CNT_W-1:0];
            end
            if (paddr == OFS_SECOND) begin
                secondary_compare_value <= pwdata[CNT_W-1:0];
            end
        end
    end

    // Read data captured in the setup phase, stable through access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_CTRL: begin
                    prdata <= {16'h0000, 2'h0, ctrl.idle_halt_select, 8'h00, pwm_fault_status,
                               ctrl.time_base_select, ctrl.compare_mode_field};
                end
                OFS_PRIMARY: prdata <= {{(32-CNT_W){1'b0}}, primary_compare_value};
                OFS_SECOND:  prdata <= {{(32-CNT_W){1'b0}}, secondary_compare_value};
                OFS_STATUS:  prdata <= {{(32-EVT_W){1'b0}}, evt_status};
                OFS_MASK:    prdata <= {{(32-EVT_W){1'b0}}, evt_mask};
                default:     prdata <= '0;
            endcase
        end
    end

    // Channel halts in Idle only when asked to, and not during mode entry
    assign run = (mode != MODE_OFF) && !(ctrl.idle_halt_select && cpu_idle) && !mode_load;

    occ_compare #(
        .CNT_W(CNT_W)
    ) u_compare (
        .second_timer_count (second_timer_count),
        .third_timer_count  (third_timer_count),
        .second_period_hit  (second_period_hit),
        .third_period_hit   (third_period_hit),
        .time_base_select   (ctrl.time_base_select),
        .value_a            (is_pwm ? duty : primary_compare_value),
        .value_b            (secondary_compare_value),
        .match              (match)
    );

    occ_edge #(
        .IDLE_LEVEL(1'b1)
    ) u_fault_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .level    (fault_input_pin),
        .rise     (),
        .fall     (fault_fall)
    );

    // Pin events that raise the channel interrupt
    always_comb begin
        cmp_evt = 1'b0;
        if (run && match.hit_primary && state == ST_ARMED &&
            (mode == MODE_SET_HIGH || mode == MODE_SET_LOW || mode == MODE_TOGGLE)) begin
            cmp_evt = 1'b1;
        end
        if (run && match.hit_secondary && state == ST_PULSE) begin
            cmp_evt = 1'b1;
        end
    end

    // Fault falling edge only counts in protected PWM
    assign flt_evt = run && (mode == MODE_PWM_FLT) && fault_fall;

    // Mode sequencer and pin; state freezes while halted
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state              <= ST_OFF;
            compare_output_pin <= 1'b0;
            duty               <= COMPARE_RST;
        end else if (mode_load) begin
            duty <= primary_compare_value;
            case (mode)
                MODE_OFF: begin
                    state              <= ST_OFF;
                    compare_output_pin <= port_level;
                end
                MODE_SET_HIGH, MODE_ONE_PULSE, MODE_PULSES: begin
                    state              <= ST_ARMED;
                    compare_output_pin <= 1'b0;
                end
                MODE_SET_LOW: begin
                    state              <= ST_ARMED;
                    compare_output_pin <= 1'b1;
                end
                MODE_TOGGLE: begin
                    state <= ST_ARMED;
                end
                default: begin
                    state              <= ST_PWM;
                    compare_output_pin <= (primary_compare_value != COMPARE_RST);
                end
            endcase
        end else if (mode == MODE_OFF) begin
            state              <= ST_OFF;
            compare_output_pin <= port_level;
        end else if (run) begin
            case (state)
                ST_ARMED: begin
                    if (match.hit_primary) begin
                        case (mode)
                            MODE_SET_HIGH: begin
                                compare_output_pin <= 1'b1;
                                state              <= ST_DONE;
                            end
                            MODE_SET_LOW: begin
                                compare_output_pin <= 1'b0;
                                state              <= ST_DONE;
                            end
                            MODE_TOGGLE: begin
                                compare_output_pin <= ~compare_output_pin;
                            end
                            default: begin
                                compare_output_pin <= 1'b1;
                                state              <= ST_PULSE;
                            end
                        endcase
                    end
                end
                ST_PULSE: begin
                    if (match.hit_secondary) begin
                        compare_output_pin <= 1'b0;
                        state <= (mode == MODE_PULSES) ? ST_ARMED : ST_DONE;
                    end
                end
                ST_PWM: begin
                    if (flt_evt) begin
                        compare_output_pin <= 1'b0;
                        state              <= ST_FAULT;
                    end else if (match.period_hit) begin
                        duty               <= secondary_compare_value;
                        compare_output_pin <= (secondary_compare_value != COMPARE_RST);
                    end else if (match.hit_primary) begin
                        compare_output_pin <= 1'b0;
                    end
                end
                ST_FAULT: begin
                    compare_output_pin <= 1'b0;
                end
                ST_DONE, ST_OFF: begin
                    compare_output_pin <= compare_output_pin;
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // Fault status: set by the fault, dropped by hardware on mode rewrite
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_fault_status <= 1'b0;
        end else if (flt_evt) begin
            pwm_fault_status <= 1'b1;
        end else if (mode_load) begin
            pwm_fault_status <= 1'b0;
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    assign evt_set = {flt_evt, cmp_evt};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_status <= EVT_RST;
            evt_mask   <= EVT_RST;
        end else begin
            if (wr && paddr == OFS_STATUS) begin
                evt_status <= (evt_status & ~pwdata[EVT_W-1:0]) | evt_set;
            end else begin
                evt_status <= evt_status | evt_set;
            end
            if (wr && paddr == OFS_MASK) begin
                evt_mask <= pwdata[EVT_W-1:0];
            end
        end
    end

    assign irq = |(evt_status & evt_mask);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence arm_match(logic [2:0] m);
        state == ST_ARMED && mode == m && run && match.hit_primary;
    endsequence

    sequence pulse_end;
        state == ST_PULSE && run && match.hit_secondary;
    endsequence

    disabled_follows_port_a: assert property (
        (mode == MODE_OFF && !mode_load) |=> compare_output_pin == $past(port_level))
        else $error("disabled pin does not follow port level");
    disabled_quiet_a: assert property (mode == MODE_OFF |-> !cmp_evt && !flt_evt)
        else $error("event raised while disabled");
    set_high_a: assert property (arm_match(MODE_SET_HIGH) |-> cmp_evt ##1 (compare_output_pin && state == ST_DONE))
        else $error("set-high match did not raise pin");
    set_low_a: assert property (arm_match(MODE_SET_LOW) |-> cmp_evt ##1 (!compare_output_pin && state == ST_DONE))
        else $error("set-low match did not drop pin");
    toggle_flip_a: assert property (arm_match(MODE_TOGGLE) |=> compare_output_pin != $past(compare_output_pin))
        else $error("toggle did not invert pin");
    single_pulse_a: assert property (
        (pulse_end and (mode == MODE_ONE_PULSE)) |-> cmp_evt ##1 (!compare_output_pin && state == ST_DONE))
        else $error("single pulse did not end");
    // Each fall of a continuous train rearms for the next primary match
    repeat_pulse_a: assert property (
        (pulse_end and (mode == MODE_PULSES)) |-> cmp_evt ##1 (!compare_output_pin && state == ST_ARMED))
        else $error("continuous pulse did not rearm");
    pwm_no_irq_a: assert property (mode == MODE_PWM |-> !cmp_evt && !flt_evt)
        else $error("event raised in plain pwm");
    pwm_start_a: assert property (
        (mode_load && is_pwm) |=> compare_output_pin == ($past(primary_compare_value) != COMPARE_RST))
        else $error("pwm start level wrong");
    fault_flag_a: assert property (flt_evt |=> pwm_fault_status && evt_status[EVT_FAULT])
        else $error("fault not flagged");
    fault_hold_a: assert property ((state == ST_FAULT && !mode_load) |=> !compare_output_pin)
        else $error("pin not held low in fault");
    duty_reload_a: assert property (
        (state == ST_PWM && run && match.period_hit && !flt_evt) |=> duty == $past(secondary_compare_value))
        else $error("duty not reloaded at period");
    idle_freeze_a: assert property (
        (mode != MODE_OFF && !mode_load && ctrl.idle_halt_select && cpu_idle)
        |=> compare_output_pin == $past(compare_output_pin) && state == $past(state))
        else $error("channel moved while halted in idle");
    reserved_zero_a: assert property (
        (acc && !pwrite && paddr == OFS_CTRL) |-> prdata[15:14] == 2'h0 && prdata[12:5] == 8'h00)
        else $error("reserved control bits read nonzero");

endmodule : occ_channel

// [logic/occ_compare.sv]
`timescale 1ns/1ps
module occ_compare
    import occ_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic [CNT_W-1:0] second_timer_count, // Count of the second timer
    input  wire logic [CNT_W-1:0] third_timer_count,  // Count of the third timer
    input  wire logic             second_period_hit,  // Second timer reached period
    input  wire logic             third_period_hit,   // Third timer reached period
    input  wire logic             time_base_select,   // High picks the third timer
    input  wire logic [CNT_W-1:0] value_a,            // Primary or active duty value
    input  wire logic [CNT_W-1:0] value_b,            // Secondary value
    output occ_match_t            match               // Equality results
);

    logic [CNT_W-1:0] count;

    // Time base choice: third timer when set, second when clear
    assign count               = time_base_select ? third_timer_count : second_timer_count;
    assign match.period_hit    = time_base_select ? third_period_hit : second_period_hit;
    // Equality against the compare values
    assign match.hit_primary   = (count == value_a);
    assign match.hit_secondary = (count == value_b);

endmodule : occ_compare

// [logic/occ_edge.sv]
`timescale 1ns/1ps
module occ_edge #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input  wire logic core_clk, // Core clock
    input  wire logic rst_n,    // Async reset, active low
    input  wire logic level,    // Sampled input level
    output logic      rise,     // Rising edge seen this cycle
    output logic      fall      // Falling edge seen this cycle
);

    logic prev;

    // Idle level at reset so a quiet line gives no false edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= IDLE_LEVEL;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule : occ_edge

// [logic/occ_pkg.sv]
package occ_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_PRIMARY = 8'h04;
    localparam logic [7:0] OFS_SECOND  = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_MASK    = 8'h10;

    // Control register field positions
    localparam int BIT_IDLE_HALT = 13;
    localparam int BIT_FAULT     = 4;
    localparam int BIT_TSEL      = 3;
    localparam int MODE_MSB      = 2;

    // Interrupt status and mask layout
    localparam int EVT_COMPARE = 0;
    localparam int EVT_FAULT   = 1;
    localparam int EVT_W       = 2;

    // Reset values
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] COMPARE_RST = 16'h0000;
    localparam logic [1:0]  EVT_RST     = 2'h0;

    // Compare mode field codes
    localparam logic [2:0] MODE_OFF      = 3'h0;
    localparam logic [2:0] MODE_SET_HIGH = 3'h1;
    localparam logic [2:0] MODE_SET_LOW  = 3'h2;
    localparam logic [2:0] MODE_TOGGLE   = 3'h3;
    localparam logic [2:0] MODE_ONE_PULSE = 3'h4;
    localparam logic [2:0] MODE_PULSES   = 3'h5;
    localparam logic [2:0] MODE_PWM      = 3'h6;
    localparam logic [2:0] MODE_PWM_FLT  = 3'h7;

    // Writable control fields travel together
    typedef struct packed {
        logic       idle_halt_select;
        logic       time_base_select;
        logic [2:0] compare_mode_field;
    } occ_ctrl_t;

    // Comparator results for the selected time base
    typedef struct packed {
        logic hit_primary;
        logic hit_secondary;
        logic period_hit;
    } occ_match_t;

    typedef enum logic [5:0] {
        ST_OFF   = 6'h01,
        ST_ARMED = 6'h02,
        ST_PULSE = 6'h04,
        ST_DONE  = 6'h08,
        ST_PWM   = 6'h10,
        ST_FAULT = 6'h20
    } occ_state_t;

endpackage : occ_pkg

// [tb/occ_load.sv]
`timescale 1ns/1ps
// Power stage behind the compare pin, with an active-low overload line
module occ_load (
    input  wire logic core_clk, // Core clock
    input  wire logic drive,    // Compare pin level
    input  wire logic trip,     // Bench orders an overload
    output logic      fault_n,  // Fault line, high while healthy
    output logic      driven    // Stage output, one cycle behind the pin
);
    initial fault_n = 1'b1;
    // Registered so the fault line only moves on the sampling edge
    always @(posedge core_clk) begin
        fault_n <= ~trip;
        driven  <= drive;
    end
endmodule : occ_load

// [tb/output_compare_channel_bench.sv]
`timescale 1ns/1ps
module output_compare_channel_bench;
    import occ_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cnt2, cnt3, v1, v2;
    logic        per2, per3, idle, port_level, trip, fault_n, pin, irq;
    int          failures = 0;
    int          checked = 0;

    // Free running core clock
    always #5 core_clk = ~core_clk;

    occ_channel DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .second_timer_count(cnt2), .third_timer_count(cnt3), .second_period_hit(per2),
        .third_period_hit(per3), .cpu_idle(idle), .fault_input_pin(fault_n), .port_level(port_level),
        .compare_output_pin(pin), .irq(irq));
    occ_load load (.core_clk(core_clk), .drive(pin), .trip(trip), .fault_n(fault_n), .driven());

    // Verdict and end of run
    task automatic final_report;
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Only idle halt, fault flag, time base and mode survive in control
    function automatic logic [31:0] exp_ctrl(input logic [31:0] w, input logic flt);
        return {18'h0, w[13], 8'h0, flt, w[3:0]};
    endfunction : exp_ctrl

    function automatic logic pwm_start(input logic [15:0] duty);
        return duty != 16'h0;
    endfunction : pwm_start

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            final_report();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Time bases stay parked at zero while control is written
    task automatic setmode(input logic [2:0] m, input logic t, input logic h);
        apb(1'b1, OFS_CTRL, {18'h0, h, 9'h0, t, m});
        repeat (2) @(posedge core_clk);
        #1;
    endtask : setmode

    // One count value on one timer for one cycle, then the pin level
    task automatic step(input logic t, input logic [15:0] v, input logic e, input string what);
        @(posedge core_clk);
        if (t) cnt3 <= v;
        else cnt2 <= v;
        @(posedge core_clk);
        cnt2 <= 16'h0;
        cnt3 <= 16'h0;
        #1;
        chk(what, {31'h0, e}, {31'h0, pin});
    endtask : step

    // Interrupt level, then clear both events and expect it gone
    task automatic clear(input logic e, input string what);
        chk(what, {31'h0, e}, {31'h0, irq});
        apb(1'b1, OFS_STATUS, 32'h3);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask : clear

    initial begin
        {psel, penable, pwrite, per2, per3, idle, port_level, trip} = 8'h0;
        {paddr, pwdata, cnt2, cnt3} = 72'h0;
        void'($urandom(32'h089b));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", {16'h0, CTRL_RST}, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped read", 32'h0, rd);
        apb(1'b1, OFS_CTRL, 32'hffff_fff8);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl bits", exp_ctrl(32'hffff_fff8, 1'b0), rd);
        port_level <= 1'b1;
        step(1'b0, 16'h0, 1'b1, "port pin");
        port_level <= 1'b0;
        apb(1'b1, OFS_MASK, 32'h3);
        for (int k = 0; k < 4; k++) begin
            v1 = 16'h1 + 16'($urandom_range(32'h7ffe));
            v2 = v1 + 16'h10;
            apb(1'b1, OFS_PRIMARY, {16'h0, v1});
            apb(1'b1, OFS_SECOND, {16'h0, v2});
            apb(1'b0, OFS_SECOND, 32'h0);
            chk("secondary", {16'h0, v2}, rd);
            setmode(MODE_SET_HIGH, k[0], 1'b0);
            step(~k[0], v1, 1'b0, "other timer");
            step(k[0], v1, 1'b1, "set high");
            clear(1'b1, "irq rise");
            setmode(MODE_SET_LOW, k[0], 1'b0);
            step(k[0], 16'h0, 1'b1, "start high");
            step(k[0], v1, 1'b0, "set low");
            clear(1'b1, "irq fall");
            setmode(MODE_TOGGLE, k[0], 1'b0);
            step(k[0], 16'h0, 1'b0, "toggle keep");
            step(k[0], v1, 1'b1, "toggle up");
            clear(1'b1, "toggle rise irq");
            step(k[0], v1, 1'b0, "toggle down");
            clear(1'b1, "toggle fall irq");
            setmode(MODE_ONE_PULSE, k[0], 1'b0);
            step(k[0], v1, 1'b1, "pulse rise");
            clear(1'b0, "pulse rise irq");
            step(k[0], v2, 1'b0, "pulse fall");
            clear(1'b1, "pulse fall irq");
            step(k[0], v1, 1'b0, "single pulse");
            setmode(MODE_PULSES, k[0], 1'b0);
            step(k[0], v1, 1'b1, "train rise");
            step(k[0], v2, 1'b0, "train fall");
            step(k[0], v1, 1'b1, "train again");
            clear(1'b1, "train irq");
        end
        setmode(MODE_OFF, 1'b0, 1'b0);
        step(1'b0, v1, 1'b0, "off pin");
        clear(1'b0, "off irq");
        setmode(MODE_SET_HIGH, 1'b0, 1'b1);
        idle <= 1'b1;
        step(1'b0, v1, 1'b0, "idle halt");
        idle <= 1'b0;
        step(1'b0, v1, 1'b1, "idle resume");
        setmode(MODE_SET_LOW, 1'b0, 1'b0);
        idle <= 1'b1;
        step(1'b0, v1, 1'b0, "idle run");
        idle <= 1'b0;
        apb(1'b1, OFS_MASK, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("masked status", 32'h1, rd);
        clear(1'b0, "masked irq");
        apb(1'b1, OFS_MASK, 32'h3);
        apb(1'b1, OFS_PRIMARY, 32'h0);
        setmode(MODE_PWM, 1'b0, 1'b0);
        step(1'b0, 16'h0, pwm_start(16'h0), "pwm zero start");
        per2 <= 1'b1;
        step(1'b0, 16'h0, pwm_start(v2), "duty reload");
        per2 <= 1'b0;
        step(1'b0, v2, 1'b0, "duty end");
        per2 <= 1'b1;
        trip <= 1'b1;
        step(1'b0, 16'h0, 1'b1, "pwm period");
        per2 <= 1'b0;
        step(1'b0, 16'h0, 1'b1, "fault ignored");
        trip <= 1'b0;
        clear(1'b0, "pwm irq");
        apb(1'b1, OFS_PRIMARY, {16'h0, v1});
        setmode(MODE_PWM_FLT, 1'b0, 1'b0);
        step(1'b0, 16'h0, pwm_start(v1), "flt start");
        trip <= 1'b1;
        step(1'b0, 16'h0, 1'b0, "fault settle");
        per2 <= 1'b1;
        step(1'b0, 16'h0, 1'b0, "fault forced");
        per2 <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("fault flag", exp_ctrl(32'h7, 1'b1), rd);
        clear(1'b1, "fault irq");
        trip <= 1'b0;
        setmode(MODE_PWM_FLT, 1'b0, 1'b0);
        chk("fault rearm", 32'h1, {31'h0, pin});
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("fault cleared", exp_ctrl(32'h7, 1'b0), rd);
        final_report();
    end
endmodule : output_compare_channel_bench
